//--- rcfir_pkg.sv
package rcfir_pkg;

	localparam int DW    = 18;
	localparam int CW    = 20;
	localparam int DEPTH = 256;
	localparam int AW    = 8;
	localparam int GUARD = 3;
	localparam int PW    = DW + CW;
	localparam int ACCW  = PW + GUARD;
	localparam int OW    = 23;
	localparam int RW    = 5;

	localparam logic [11:0] IDX_COEF   = 12'h000;
	localparam logic [11:0] IDX_IDATA  = 12'h100;
	localparam logic [11:0] IDX_QDATA  = 12'h200;
	localparam logic [11:0] IDX_OFFSET = 12'h30B;
	localparam logic [11:0] IDX_TAPS   = 12'h30C;
	localparam logic [11:0] IDX_RATIO  = 12'h30D;
	localparam logic [11:0] IDX_STATUS = 12'h30E;

	localparam logic [3:0] PAGE_COEF = IDX_COEF[11:8];
	localparam logic [3:0] PAGE_I    = IDX_IDATA[11:8];
	localparam logic [3:0] PAGE_Q    = IDX_QDATA[11:8];
	localparam logic [3:0] PAGE_REG  = IDX_OFFSET[11:8];

	localparam logic [AW-1:0] RST_OFFSET = 8'h00;
	localparam logic [AW-1:0] RST_TAPS   = 8'h00;
	localparam logic [RW-1:0] RST_RATIO  = 5'h00;

	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WPTR_LSB = 8;
	localparam int ST_CNT_LSB  = 16;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MAC  = 3'b010,
		ST_DONE = 3'b100
	} rcfir_state_t;

endpackage

//--- rcfir_top.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
module rcfir_top
	import rcfir_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rstn_i,
	input  wire logic          ce_i,
	input  wire logic          cyc_i,
	input  wire logic          stb_i,
	input  wire logic          we_i,
	input  wire logic [13:0]   adr_i,
	input  wire logic [3:0]    sel_i,
	input  wire logic [31:0]   dat_i,
	output logic      [31:0]   dat_o,
	output logic               ack_o,
	input  wire logic          in_valid_i,
	output logic               in_ready_o,
	input  wire logic [DW-1:0] in_i_i,
	input  wire logic [DW-1:0] in_q_i,
	output logic               out_valid_o,
	input  wire logic          out_ready_i,
	output logic      [OW-1:0] out_i_o,
	output logic      [OW-1:0] out_q_o
);

	function automatic logic [31:0] wmerge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		begin
			r = old_w;
			for (int b = 0; b < 4; b++)
			begin
				if (sel[b])
					r[b*8 +: 8] = new_w[b*8 +: 8];
			end
			return r;
		end
	endfunction

	function automatic logic signed [ACCW-1:0] mac(
		input logic signed [ACCW-1:0] acc,
		input logic signed [DW-1:0]   d,
		input logic signed [CW-1:0]   c
	);
		logic signed [PW-1:0] p;
		begin
			p = d * c;
			return acc + ACCW'(p);
		end
	endfunction

	logic [CW-1:0]        coef_mem [DEPTH];
	logic [DW-1:0]        imem     [DEPTH];
	logic [DW-1:0]        qmem     [DEPTH];

	logic [AW-1:0]        off_r;
	logic [AW-1:0]        taps_r;
	logic [RW-1:0]        ratio_r;
	logic                 ack_r;
	logic [31:0]          dat_r;

	rcfir_state_t         state_r;
	rcfir_state_t         state_nxt;
	logic                 in_ready_r;
	logic [AW-1:0]        wptr_r;
	logic [RW-1:0]        dcnt_r;
	logic [AW-1:0]        base_r;
	logic [AW-1:0]        k_r;

	logic                 v1_r;
	logic                 last1_r;
	logic signed [DW-1:0] di_r;
	logic signed [DW-1:0] dq_r;
	logic signed [CW-1:0] c_r;
	logic signed [ACCW-1:0] acc_i_r;
	logic signed [ACCW-1:0] acc_q_r;
	logic                 fin_r;

	logic [1:0]           cnt_r;
	logic                 out_valid_r;
	logic [OW-1:0]        b0_i_r;
	logic [OW-1:0]        b0_q_r;
	logic [OW-1:0]        b1_i_r;
	logic [OW-1:0]        b1_q_r;

	logic                 req;
	logic                 wr;
	logic [11:0]          idx;
	logic [3:0]           page;
	logic [AW-1:0]        ra;
	logic                 take;
	logic                 trig;
	logic                 push;
	logic                 pop;
	logic [OW-1:0]        res_i;
	logic [OW-1:0]        res_q;

	assign req   = cyc_i & stb_i & ~ack_r;
	assign wr    = req & we_i;
	assign idx   = adr_i[13:2];
	assign page  = idx[11:8];
	assign ra    = idx[7:0];
	assign take  = in_valid_i & in_ready_r;
	assign trig  = take & (dcnt_r == ratio_r);
	// Top 23 of the 41 accumulator bits; low product bits are dropped
	assign res_i = acc_i_r[ACCW-1 -: OW];
	assign res_q = acc_q_r[ACCW-1 -: OW];
	// One result in flight, so a full buffer simply holds the engine in DONE
	assign push  = (state_r == ST_DONE) & fin_r & (cnt_r != 2'd2);
	assign pop   = out_valid_r & out_ready_i;

	assign dat_o       = dat_r;
	assign ack_o       = ack_r;
	assign in_ready_o  = in_ready_r;
	assign out_valid_o = out_valid_r;
	assign out_i_o     = b0_i_r;
	assign out_q_o     = b0_q_r;

	// Bus slave: while ce_i is high, every access answers one cycle after the request
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ack_r <= 1'b0;
		else if (ce_i)
			ack_r <= req;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			off_r   <= RST_OFFSET;
			taps_r  <= RST_TAPS;
			ratio_r <= RST_RATIO;
		end
		else if (ce_i && wr && page == PAGE_REG)
		begin
			if (idx == IDX_OFFSET)
				off_r <= AW'(wmerge(32'(off_r), dat_i, sel_i));
			if (idx == IDX_TAPS)
				taps_r <= AW'(wmerge(32'(taps_r), dat_i, sel_i));
			if (idx == IDX_RATIO)
				ratio_r <= RW'(wmerge(32'(ratio_r), dat_i, sel_i));
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			dat_r <= 32'h0000_0000;
		else if (ce_i && req)
		begin
			dat_r <= 32'h0000_0000;
			unique case (page)
				PAGE_COEF: dat_r <= 32'(coef_mem[ra]);
				PAGE_I:    dat_r <= 32'(imem[ra]);
				PAGE_Q:    dat_r <= 32'(qmem[ra]);
				PAGE_REG:
				begin
					if (idx == IDX_OFFSET)
						dat_r <= 32'(off_r);
					else if (idx == IDX_TAPS)
						dat_r <= 32'(taps_r);
					else if (idx == IDX_RATIO)
						dat_r <= 32'(ratio_r);
					else if (idx == IDX_STATUS)
					begin
						dat_r[ST_BUSY_BIT]          <= (state_r != ST_IDLE);
						dat_r[ST_WPTR_LSB +: AW]    <= wptr_r;
						dat_r[ST_CNT_LSB +: 2]      <= cnt_r;
					end
				end
				default: dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// Coefficient memory, signed 20-bit words at indices 0x000..0x0FF
	always_ff @(posedge clk_i)
	begin
		if (ce_i && wr && page == PAGE_COEF)
			coef_mem[ra] <= CW'(wmerge(32'(coef_mem[ra]), dat_i, sel_i));
	end

	// Sample memories; a stream write to the same word wins over software
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (wr && page == PAGE_I)
				imem[ra] <= DW'(wmerge(32'(imem[ra]), dat_i, sel_i));
			if (wr && page == PAGE_Q)
				qmem[ra] <= DW'(wmerge(32'(qmem[ra]), dat_i, sel_i));
			if (take)
			begin
				imem[wptr_r] <= in_i_i;
				qmem[wptr_r] <= in_q_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wptr_r <= '0;
			dcnt_r <= '0;
		end
		else if (ce_i && take)
		begin
			wptr_r <= wptr_r + 8'h01;
			dcnt_r <= trig ? '0 : dcnt_r + 5'h01;
		end
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (trig) state_nxt = ST_MAC;
			ST_MAC:  if (k_r == taps_r) state_nxt = ST_DONE;
			ST_DONE: if (push) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_r    <= ST_IDLE;
			in_ready_r <= 1'b0;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			// Input waits while a result is computed so the window stays intact
			in_ready_r <= (state_nxt == ST_IDLE);
		end
	end

	// Oldest sample of the window is the new write pointer less the tap count
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			base_r <= '0;
			k_r    <= '0;
		end
		else if (ce_i)
		begin
			if (trig)
			begin
				base_r <= wptr_r - taps_r;
				k_r    <= '0;
			end
			else if (state_r == ST_MAC)
				k_r <= k_r + 8'h01;
		end
	end

	// Read stage: one coefficient feeds both paths
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			v1_r    <= 1'b0;
			last1_r <= 1'b0;
			di_r    <= '0;
			dq_r    <= '0;
			c_r     <= '0;
		end
		else if (ce_i)
		begin
			v1_r    <= (state_r == ST_MAC);
			last1_r <= (state_r == ST_MAC) && (k_r == taps_r);
			di_r    <= imem[base_r + k_r];
			dq_r    <= qmem[base_r + k_r];
			c_r     <= coef_mem[off_r + k_r];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			acc_i_r <= '0;
			acc_q_r <= '0;
			fin_r   <= 1'b0;
		end
		else if (ce_i)
		begin
			if (trig)
			begin
				acc_i_r <= '0;
				acc_q_r <= '0;
				fin_r   <= 1'b0;
			end
			else if (v1_r)
			begin
				acc_i_r <= mac(acc_i_r, di_r, c_r);
				acc_q_r <= mac(acc_q_r, dq_r, c_r);
				fin_r   <= last1_r;
			end
			else if (push)
				fin_r <= 1'b0;
		end
	end

	// Two-entry output buffer; entry 0 drives the ports directly
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_r       <= 2'd0;
			out_valid_r <= 1'b0;
			b0_i_r      <= '0;
			b0_q_r      <= '0;
			b1_i_r      <= '0;
			b1_q_r      <= '0;
		end
		else if (ce_i)
		begin
			if (push && pop)
			begin
				b0_i_r <= res_i;
				b0_q_r <= res_q;
			end
			else if (pop)
			begin
				b0_i_r      <= b1_i_r;
				b0_q_r      <= b1_q_r;
				cnt_r       <= cnt_r - 2'd1;
				out_valid_r <= (cnt_r == 2'd2);
			end
			else if (push)
			begin
				if (cnt_r == 2'd0)
				begin
					b0_i_r <= res_i;
					b0_q_r <= res_q;
				end
				else
				begin
					b1_i_r <= res_i;
					b1_q_r <= res_q;
				end
				cnt_r       <= cnt_r + 2'd1;
				out_valid_r <= 1'b1;
			end
		end
	end

endmodule

//--- rcfir_monitor.sv
`timescale 1ns/1ns
module rcfir_monitor
	import rcfir_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          rstn_i,
	input wire logic          cyc_i,
	input wire logic          stb_i,
	input wire logic          ack_o,
	input wire logic          in_ready_o,
	input wire logic          out_valid_o,
	input wire logic          out_ready_i,
	input wire logic [OW-1:0] out_i_o,
	input wire logic [OW-1:0] out_q_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence trig_s;
		$fell(in_ready_o);
	endsequence
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o)) else $error("stray ack");
	AST_ACK_REQ: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable({out_i_o, out_q_o}))
		else $error("result moved");
	AST_BUSY_MIN: assert property (trig_s |-> !in_ready_o [*3]) else $error("idle too soon");
	AST_OUT_BOUND: assert property (trig_s |-> ##[3:300] out_valid_o) else $error("no result");
	AST_OUT_AFTER: assert property ($rose(out_valid_o) |-> $past(!in_ready_o)) else $error("result unasked");
	// Depth two skips the ready rise that follows reset release
	AST_RDY_AFTER: assert property ($rose(in_ready_o) && $past(rstn_i, 2) |-> out_valid_o) else $error("lost");
endmodule
bind rcfir_top rcfir_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_i_o(out_i_o),
	.out_q_o(out_q_o));

//--- rcfir_src.sv
`timescale 1ns/1ns
module rcfir_src
	import rcfir_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          ready_i,
	output logic               valid_o,
	output logic      [DW-1:0] i_o,
	output logic      [DW-1:0] q_o
);
	int gap = 7;
	int to = 0;
	initial
	begin
		valid_o = 0;
		i_o = 0;
		q_o = 0;
	end
	task automatic send(input logic [DW-1:0] i, input logic [DW-1:0] q);
		int n;
		valid_o <= 1;
		i_o <= i;
		q_o <= q;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ready_i !== 1'b1 && n < 4000);
		to += (n >= 4000);
		// Released lines show the inverse so a stale sample cannot pass
		valid_o <= 0;
		i_o <= ~i;
		q_o <= ~q;
		repeat (gap) @(posedge clk_i);
	endtask
endmodule

//--- rcfir_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb
	import rcfir_pkg::*;
;
	logic            clk_i, rstn_i, cyc_i, stb_i, we_i, ack_o, stall;
	logic            in_valid_i, in_ready_o, out_valid_o, out_ready_i;
	logic [13:0]     adr_i;
	logic [3:0]      sel_i;
	logic [31:0]     dat_i, dat_o;
	logic [DW-1:0]   in_i_i, in_q_i;
	logic [OW-1:0]   out_i_o, out_q_o;
	logic [CW-1:0]   cf [256];
	logic [DW-1:0]   hi[$], hq[$];
	logic [2*OW-1:0] eq[$];
	int              error_cnt, num_checks;
	int              nsamp;
	rcfir_top u_rcfir_top (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .in_valid_i(in_valid_i),
		.in_ready_o(in_ready_o), .in_i_i(in_i_i), .in_q_i(in_q_i), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i), .out_i_o(out_i_o), .out_q_o(out_q_o));
	rcfir_src u_rcfir_src (.clk_i(clk_i), .ready_i(in_ready_o), .valid_o(in_valid_i), .i_o(in_i_i), .q_o(in_q_i));
	initial
	begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	task finish_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task hung();
		error_cnt++;
		finish_test();
	endtask
	task automatic bus(input logic w, input logic [11:0] x, input logic [31:0] d, output logic [31:0] r);
		int n;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= {x, 2'b00};
		dat_i <= d;
		sel_i <= 4'hF;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		r = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		if (n >= 50)
			hung();
		@(posedge clk_i);
	endtask
	// Oldest of the last t samples meets coefficient o; the sum wraps at the accumulator width
	function automatic logic [OW-1:0] fir(input logic [DW-1:0] h[$], input int t, input int o);
		logic signed [ACCW-1:0] a;
		a = 0;
		for (int k = 0; k < t; k++)
			a += $signed(h[h.size() - t + k]) * $signed(cf[8'(o + k)]);
		return a[ACCW-1:ACCW-OW];
	endfunction
	task automatic feed(input int m, input int t, input int o, inout int g);
		logic [DW-1:0] a;
		logic [DW-1:0] b;
		a = ($urandom % 5 == 0) ? 18'h2_0000 : DW'($urandom);
		b = ~a ^ DW'($urandom);
		hi.push_back(a);
		hq.push_back(b);
		nsamp++;
		// Queue the expectation first: the result can appear during the source's gap
		if (++g == m)
		begin
			g = 0;
			eq.push_back({fir(hi, t, o), fir(hq, t, o)});
		end
		u_rcfir_src.send(a, b);
	endtask
	always @(posedge clk_i)
	begin
		if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
		begin
			`CHK("out_i", eq[0][2*OW-1:OW], out_i_o)
			`CHK("out_q", eq[0][OW-1:0], out_q_o)
			void'(eq.pop_front());
		end
		out_ready_i <= !stall && ($urandom % 4 != 0);
	end
	initial
	begin
		logic [31:0] r;
		int          m, t, o, g;
		int          cm[4] = '{1, 3, 32, 2};
		int          ct[4] = '{1, 5, 256, 8};
		int          co[4] = '{0, 254, 7, 128};
		r = $urandom(70);
		{rstn_i, cyc_i, stb_i, we_i, adr_i, dat_i, stall, out_ready_i, error_cnt, num_checks} = 0;
		sel_i = 4'hF;
		repeat (256) hi.push_back(0);
		hq = hi;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1;
		@(posedge clk_i);
		for (int x = 'h100; x < 'h300; x++)
			bus(1, 12'(x), 0, r);
		for (int x = 0; x < 256; x++)
		begin
			cf[x] = (x == 0) ? 20'h8_0000 : CW'($urandom);
			bus(1, 12'(x), 32'(cf[x]), r);
		end
		bus(0, 12'h05A, 0, r);
		`CHK("coef", 32'(cf[90]), r)
		bus(0, 12'h3FF, 0, r);
		`CHK("unmapped", 32'h0000_0000, r)
		for (int c = 0; c < 6; c++)
		begin
			m = (c < 4) ? cm[c] : 1 + $urandom % 32;
			t = (c < 4) ? ct[c] : 1 + $urandom % (8 * m);
			o = (c < 4) ? co[c] : $urandom % 256;
			u_rcfir_src.gap = (c == 5) ? 19 : 7;
			bus(1, IDX_OFFSET, o, r);
			bus(1, IDX_TAPS, t - 1, r);
			bus(1, IDX_RATIO, m - 1, r);
			bus(0, IDX_TAPS, 0, r);
			`CHK("taps", 32'(t - 1), r)
			bus(0, IDX_RATIO, 0, r);
			`CHK("ratio", 32'(m - 1), r)
			g = 0;
			if (c == 0)
			begin
				stall <= 1;
				fork
					repeat (4) feed(m, t, o, g);
					begin
						repeat (80) @(posedge clk_i);
						`CHK("in_ready", 1'b0, in_ready_o)
						stall <= 0;
					end
				join
			end
			repeat (3 * m) feed(m, t, o, g);
			for (int n = 0; eq.size() > 0; n++)
			begin
				if (n > 9000)
					hung();
				@(posedge clk_i);
			end
		end
		`CHK("src wait", 0, u_rcfir_src.to)
		bus(0, IDX_STATUS, 0, r);
		`CHK("status", 32'(8'(nsamp)) << ST_WPTR_LSB, r)
		bus(0, IDX_IDATA + 12'((nsamp - 1) % 256), 0, r);
		`CHK("i sample", 32'(hi[$]), r)
		bus(0, IDX_QDATA + 12'((nsamp - 1) % 256), 0, r);
		`CHK("q sample", 32'(hq[$]), r)
		finish_test();
	end
endmodule
